// file: verilog/sar_adc_consts.svh
// Constants for the successive-approximation converter control block:
// register indices, field positions, reset values and timing counts.
// Assumes a 200 MHz system clock and a fixed divided oscillator rate.
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CMR          6'h1c
`define IDX_TLR          6'h1d
`define IDX_LRS          6'h1e
`define IDX_UPR          6'h1f

// ==========================================================
// Reset values of the control registers
`define CMR_RESET        8'h10
`define TLR_RESET        8'h00

// ==========================================================
// Field positions, channel/mode control register
`define CMR_START_BIT    7
`define CMR_MODE_HI      6
`define CMR_MODE_LO      5
`define CMR_INDIS_BIT    4
`define CMR_CHAN_HI      3
`define CMR_CHAN_LO      0

// Field positions, time/ladder control register
`define TLR_LADDER_BIT   5
`define TLR_TIME_HI      3
`define TLR_TIME_LO      1

// Field positions, low result/status register
`define LRS_DONE_BIT     5
`define LRS_BUSY_BIT     4

// ==========================================================
// Operating modes
`define MODE_OFF         2'b00
`define MODE_SW          2'b01
`define MODE_RPT         2'b11

// ==========================================================
// Conversion-time codes and their length in oscillator periods
`define TIME_39          3'b000
`define TIME_78          3'b010
`define TIME_156         3'b011
`define TIME_312         3'b100
`define TIME_624         3'b101
`define TIME_1248        3'b110
`define FC_PERIODS_39    11'd39
`define FC_PERIODS_78    11'd78
`define FC_PERIODS_156   11'd156
`define FC_PERIODS_312   11'd312
`define FC_PERIODS_624   11'd624
`define FC_PERIODS_1248  11'd1248

// ==========================================================
// Clock rates; oscillator period as a count of system clocks
`define CLK_FREQ_HZ      200000000
`define FC_FREQ_HZ       20000000
`define FC_DIV           (`CLK_FREQ_HZ / `FC_FREQ_HZ)

`endif

// file: verilog/sar_adc_pkg.sv
// Types shared by the converter control block and its sequencer.
// Assumes the constants header supplies all numeric values.
package sar_adc_pkg;
  // Conversion length in oscillator periods
  typedef logic [10:0] fc_len_t;
  // Ten-bit converter code
  typedef logic [9:0]  code_t;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_DECIDE} seq_state_t;
endpackage

// file: verilog/sar_sequencer.sv
// Successive-approximation sequencer: times one conversion in oscillator
// periods and makes ten decisions from the comparator.
// Assumes go, abort and restart come from the control logic on CLK.
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_sequencer
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                go,
  input  wire logic                abort,
  input  wire logic                restart,
  input  wire sar_adc_pkg::fc_len_t conv_len,
  input  wire logic                cmp_in,
  output logic                     busy,
  output sar_adc_pkg::code_t       dac_code,
  output logic                     sample_hold,
  output logic                     finish,
  output sar_adc_pkg::code_t       finish_code
);
  import sar_adc_pkg::*;

  seq_state_t state_reg;          // Sequencer state
  logic [3:0] div_reg;            // Oscillator-period divider
  fc_len_t    cnt_reg;            // Periods since sampling began
  fc_len_t    mark_reg;           // Period of the next decision
  logic [3:0] bit_idx_reg;        // Bit under trial
  code_t      trial_next;         // Trial code after this decision
  logic [15:0] span_reg;          // Cycle count, checked only
  logic       tick;               // One oscillator period elapsed
  logic       begin_sample;       // A conversion starts now
  fc_len_t    step;               // Periods per decision
  fc_len_t    first_mark;         // End of the sampling phase
  fc_len_t    cnt_inc;            // Period count after this tick

  // ==========================================================
  // Timing arithmetic
  assign tick       = (div_reg == 4'(`FC_DIV - 1));
  assign step       = conv_len >> 4;
  assign first_mark = conv_len - fc_len_t'((step << 3) + (step << 1));
  assign cnt_inc    = cnt_reg + 11'd1;
  assign busy       = (state_reg != SEQ_IDLE);
  assign begin_sample = ((state_reg == SEQ_IDLE) & go & ~abort)
                      | (finish & restart);

  // Keep the tried bit if the input is above the ladder, try the next
  always_comb
  begin
    trial_next = dac_code;
    trial_next[bit_idx_reg] = cmp_in;
    if (bit_idx_reg != 4'd0)
      trial_next[bit_idx_reg - 4'd1] = 1'b1;
  end

  assign finish = (state_reg == SEQ_DECIDE) & tick & (cnt_inc == mark_reg)
                & (bit_idx_reg == 4'd0) & ~abort;
  assign finish_code = trial_next;

  // ==========================================================
  // Divider restarts with each conversion so its length is exact
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_reg <= 4'h0;
    else if (begin_sample || tick)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  // ==========================================================
  // Sample, then ten decisions, the last on the final period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg   <= SEQ_IDLE;
      cnt_reg     <= 11'h000;
      mark_reg    <= 11'h000;
      bit_idx_reg <= 4'h0;
      dac_code    <= 10'h000;
      sample_hold <= 1'b0;
    end
    else if (abort)
    begin
      // Stop at once; the partial code is dropped
      state_reg   <= SEQ_IDLE;
      dac_code    <= 10'h000;
      sample_hold <= 1'b0;
    end
    else if (begin_sample)
    begin
      state_reg   <= SEQ_SAMPLE;
      cnt_reg     <= 11'h000;
      mark_reg    <= first_mark;
      dac_code    <= 10'h000;
      sample_hold <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        SEQ_IDLE:
        begin
          sample_hold <= 1'b0;
        end
        SEQ_SAMPLE:
        begin
          if (tick)
          begin
            cnt_reg <= cnt_inc;
            if (cnt_inc == mark_reg)
            begin
              sample_hold <= 1'b0;
              dac_code    <= 10'h200;
              bit_idx_reg <= 4'd9;
              mark_reg    <= mark_reg + step;
              state_reg   <= SEQ_DECIDE;
            end
          end
        end
        SEQ_DECIDE:
        begin
          if (tick)
          begin
            cnt_reg <= cnt_inc;
            if (cnt_inc == mark_reg)
            begin
              if (bit_idx_reg == 4'd0)
              begin
                state_reg <= SEQ_IDLE;
                dac_code  <= 10'h000;
              end
              else
              begin
                dac_code    <= trial_next;
                bit_idx_reg <= bit_idx_reg - 4'd1;
                mark_reg    <= mark_reg + step;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Cycles since the conversion began, read only by a check
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      span_reg <= 16'h0000;
    else if (begin_sample)
      span_reg <= 16'h0000;
    else if (busy)
      span_reg <= span_reg + 16'h0001;
  end

  a_conv_length: assert property (@(posedge clk) disable iff (!arst_n)
    finish |-> span_reg == 16'(conv_len * `FC_DIV - 1))
    else $error("conversion length differs from selected period count");

endmodule

// file: verilog/sar_adc_control.sv
// Control and status of a ten-bit successive-approximation converter,
// reached by software over APB; sequencer instantiated below.
// Assumes an APB master on CLK and a comparator output sampled on CLK.
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_control
(
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                STANDBY,
  input  wire logic                CMP_IN,
  output logic [15:0]              ANALOG_IN_SEL,
  output logic                     INPUT_DISABLE,
  output logic                     LADDER_ON,
  output wire logic                SAMPLE_HOLD,
  output wire sar_adc_pkg::code_t  DAC_CODE,
  output logic                     CONV_DONE_IRQ
);
  import sar_adc_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0] channel_mode_control_reg;  // Start, mode, disable, channel
  logic [7:0] time_ladder_control_reg;   // Ladder and conversion time
  code_t      result_reg;                // Last completed conversion
  logic       conv_done_flag;            // Set at completion
  logic [5:0] idx;                       // Word index of the access
  logic       hit;                       // Address maps to a register
  logic       access;                    // Access phase completes now
  logic       wr_cmr;                    // Write to channel/mode
  logic       wr_tlr;                    // Write to time/ladder
  logic       rd_upper;                  // Read of upper result
  logic [7:0] read_mux;                  // Byte the read returns
  logic [1:0] op_mode_field;             // Operating mode
  logic       mode_run;                  // Mode allows conversions
  logic       go;                        // A requested conversion begins
  logic       abort;                     // Conversion must stop now
  logic       restart;                   // Start next on completion
  logic       conv_busy_flag;            // Sequencer is converting
  logic       finish;                    // Last decision made
  code_t      finish_code;               // Code of that conversion
  fc_len_t    conv_len;                  // Selected length in periods

  // ==========================================================
  // Conversion length for a time code; reserved codes take the
  // longest length so a bad setting never shortens the settling
  function automatic fc_len_t conv_periods(input logic [2:0] code);
    fc_len_t len;
    unique case (code)
      `TIME_39:   len = `FC_PERIODS_39;
      `TIME_78:   len = `FC_PERIODS_78;
      `TIME_156:  len = `FC_PERIODS_156;
      `TIME_312:  len = `FC_PERIODS_312;
      `TIME_624:  len = `FC_PERIODS_624;
      `TIME_1248: len = `FC_PERIODS_1248;
      default:    len = `FC_PERIODS_1248;
    endcase
    return len;
  endfunction

  // ==========================================================
  // Bus decode
  assign idx    = PADDR[7:2];
  assign hit    = (PADDR[1:0] == 2'b00)
                & ((idx == `IDX_CMR) | (idx == `IDX_TLR)
                 | (idx == `IDX_LRS) | (idx == `IDX_UPR));
  assign access = PSEL & PENABLE & PREADY;
  assign wr_cmr = access & PWRITE & hit & (idx == `IDX_CMR);
  assign wr_tlr = access & PWRITE & hit & (idx == `IDX_TLR);
  assign rd_upper = access & ~PWRITE & hit & (idx == `IDX_UPR);

  // ==========================================================
  // Mode decode and conversion control
  assign op_mode_field = channel_mode_control_reg[`CMR_MODE_HI:`CMR_MODE_LO];
  // Reserved mode code is treated like disable
  assign mode_run = (op_mode_field == `MODE_SW)
                  | (op_mode_field == `MODE_RPT);
  // Software start and repeat both begin on the start bit
  assign go       = channel_mode_control_reg[`CMR_START_BIT] & mode_run
                  & ~conv_busy_flag & ~STANDBY;
  // Disable or standby stops a running conversion at once
  assign abort    = STANDBY | ~mode_run;
  assign restart  = (op_mode_field == `MODE_RPT);
  assign conv_len = conv_periods(
    time_ladder_control_reg[`TLR_TIME_HI:`TLR_TIME_LO]);

  // ==========================================================
  // Read data; top two time/ladder bits and low four status bits read as zero
  always_comb
  begin
    unique case (idx)
      `IDX_CMR: read_mux = channel_mode_control_reg;
      `IDX_TLR: read_mux = {2'b00, time_ladder_control_reg[5:0]};
      `IDX_LRS: read_mux = {result_reg[1:0], conv_done_flag,
                            conv_busy_flag, 4'h0};
      `IDX_UPR: read_mux = result_reg[9:2];
      default:  read_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // APB slave: no wait states; ready is raised in the access phase
  // and unmapped or unaligned addresses answer with an error
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~hit;
      if (PSEL && !PENABLE && !PWRITE && hit)
        PRDATA <= {24'h00_0000, read_mux};
      else
        PRDATA <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Channel/mode register; standby forces the reset value and
  // blocks writes, so nothing restarts on return to normal mode
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      channel_mode_control_reg <= `CMR_RESET;
    else if (STANDBY)
      channel_mode_control_reg <= `CMR_RESET;
    else if (wr_cmr)
      channel_mode_control_reg <= PWDATA[7:0];
    else if (go || !mode_run)
      // Consumed when conversion begins, dropped in disable mode
      channel_mode_control_reg[`CMR_START_BIT] <= 1'b0;
  end

  // ==========================================================
  // Time/ladder register; stored as written, top bits read as zero
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      time_ladder_control_reg <= `TLR_RESET;
    else if (STANDBY)
      time_ladder_control_reg <= `TLR_RESET;
    else if (wr_tlr)
      time_ladder_control_reg <= PWDATA[7:0];
  end

  // ==========================================================
  // Result is loaded only by a completed conversion; standby loses it
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      result_reg <= 10'h000;
    else if (STANDBY)
      result_reg <= 10'h000;
    else if (finish)
      result_reg <= finish_code;
  end

  // ==========================================================
  // Done flag: completion wins over any clear in the same cycle
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      conv_done_flag <= 1'b0;
    else if (STANDBY)
      conv_done_flag <= 1'b0;
    else if (finish)
      conv_done_flag <= 1'b1;
    else if (go)
      conv_done_flag <= 1'b0;
    else if (rd_upper)
      conv_done_flag <= 1'b0;
  end

  // ==========================================================
  // Interrupt request pulse on the same edge as the done flag
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      CONV_DONE_IRQ <= 1'b0;
    else
      CONV_DONE_IRQ <= finish;
  end

  // ==========================================================
  // Analog front-end controls
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ANALOG_IN_SEL <= 16'h0000;
      INPUT_DISABLE <= 1'b1;
      LADDER_ON     <= 1'b0;
    end
    else
    begin
      // Binary channel code to one of sixteen input switches
      if (channel_mode_control_reg[`CMR_INDIS_BIT])
        ANALOG_IN_SEL <= 16'h0000;
      else
        ANALOG_IN_SEL <= 16'h0001 << channel_mode_control_reg[3:0];
      INPUT_DISABLE <= channel_mode_control_reg[`CMR_INDIS_BIT];
      // Ladder draws current, so it is off when idle unless held on
      LADDER_ON <= time_ladder_control_reg[`TLR_LADDER_BIT]
                 | go | (conv_busy_flag & ~abort);
    end
  end

  // ==========================================================
  // Conversion sequencer; busy comes from its state
  sar_sequencer u_seq
  (
    .clk         (CLK),
    .arst_n      (ARST_N),
    .go          (go),
    .abort       (abort),
    .restart     (restart),
    .conv_len    (conv_len),
    .cmp_in      (CMP_IN),
    .busy        (conv_busy_flag),
    .dac_code    (DAC_CODE),
    .sample_hold (SAMPLE_HOLD),
    .finish      (finish),
    .finish_code (finish_code)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_start_self_clear: assert property (
    go && !wr_cmr |=> !channel_mode_control_reg[`CMR_START_BIT])
    else $error("start bit did not clear after conversion began");

  a_done_load: assert property (
    finish |=> conv_done_flag && CONV_DONE_IRQ
               && result_reg == $past(finish_code))
    else $error("completion did not load result, flag and request");

  a_upper_read_clear: assert property (
    rd_upper && !finish |=> !conv_done_flag)
    else $error("upper result read did not clear done flag");

  a_busy_at_start: assert property (
    go |=> conv_busy_flag ##0 $rose(conv_busy_flag))
    else $error("busy flag not raised when conversion began");

  a_standby_reset: assert property (
    STANDBY |=> !conv_busy_flag
      && channel_mode_control_reg == `CMR_RESET
      && time_ladder_control_reg == `TLR_RESET)
    else $error("standby did not reset control and busy");

  a_disable_drop: assert property (
    !mode_run && !STANDBY |=> $stable(result_reg) && !conv_busy_flag)
    else $error("disable mode did not abort or changed result");

  // A disable or standby in the cycle after completion may stop the
  // next conversion at once, so the second cycle allows for an abort
  a_repeat_next: assert property (
    finish && restart |=> conv_busy_flag
      ##1 (conv_busy_flag || $past(abort)))
    else $error("repeat mode did not start next conversion");

  a_restart_keep: assert property (
    go && !finish |=> !conv_done_flag && $stable(result_reg))
    else $error("new start did not clear done or lost old result");

endmodule

// file: dv/analog_source_model.sv
// Comparator and sixteen analog inputs seen by the converter block.
// Assumes the bench sets a base level; input n sits n*8+5 codes above it.
`timescale 1ns/1ps
module analog_source_model
(
  input  wire logic [15:0]        sel,
  input  wire logic               in_dis,
  input  wire logic [9:0]         base,
  input  wire sar_adc_pkg::code_t dac,
  output logic                    cmp
);
  import sar_adc_pkg::*;
  logic [9:0] volt; // Level on the selected input
  // ==========================================================
  // Comparator; an unselected or gated input never reads high
  always_comb
  begin
    volt = base;
    for (int n = 0; n < 16; n++)
    begin
      if (sel[n]) volt = base + {n[6:0], 3'b101};
    end
    cmp = !in_dis && (|sel) && (volt >= dac);
  end
endmodule

// file: dv/test_sar_adc_control.sv
// Self-checking bench for the converter control block over APB.
// Assumes the analog model file and the design package are compiled first.
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module test_sar_adc_control;
  import sar_adc_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        standby = 0, pready, pslverr, cmp, in_dis, ladder, sh, irq;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] in_sel;
  code_t       dac;
  logic [9:0]  base = 10'h000;
  logic [32:0] exp_q[$];          // Expected {error, read data}
  int          n_mismatch = 0, checked = 0, cyc = 0;
  int          lens[6] = '{39, 78, 156, 312, 624, 1248};
  logic [2:0]  codes[6] = '{`TIME_39, `TIME_78, `TIME_156,
                            `TIME_312, `TIME_624, `TIME_1248};
  // ==========================================================
  // Clock, cycle count, design and analog side
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  sar_adc_control u_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STANDBY(standby), .CMP_IN(cmp), .ANALOG_IN_SEL(in_sel),
    .INPUT_DISABLE(in_dis), .LADDER_ON(ladder), .SAMPLE_HOLD(sh),
    .DAC_CODE(dac), .CONV_DONE_IRQ(irq));
  analog_source_model u_src (.sel(in_sel), .in_dis(in_dis), .base(base),
    .dac(dac), .cmp(cmp));
  // ==========================================================
  // Checking and closing
  task check(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Read results are matched in order against the noted expectations
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h0);
  // ==========================================================
  // APB master; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
           input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    if (!wr) exp_q.push_back(e);
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) check(1'b1, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask
  // Wait up to lim cycles for the completion pulse; t is the cycle seen
  task wait_irq(input int lim, output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (irq !== 1'b1 && n < lim);
    t = cyc;
  endtask
  // ==========================================================
  // Watchdog, well past the expected run of about 40k cycles
  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [9:0] res;
    logic [3:0] ch;
    logic [7:0] ctl, tl;
    logic [1:0] prev;
    int         t0, t1;
    void'($urandom(94030));
    prev = 2'b00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    check(in_dis, 1'b1);
    rd(8'h70, 8'h10);
    rd(8'h74, 8'h00);
    rd(8'h78, 8'h00);
    apb(1'b0, 8'h40, 8'h00, {1'b1, 32'h0});
    // Single conversions at the six defined time codes, ladder bit alternating
    for (int i = 0; i < 6; i++)
    begin
      ch = 4'($urandom);
      tl = {2'b00, i[0], 1'b1, codes[i], 1'b0};
      ctl = {3'b001, 1'b0, ch};
      wr(8'h74, tl);
      base <= 10'($urandom);
      wr(8'h70, ctl);
      rd(8'h74, tl);
      check({in_dis, in_sel}, {1'b0, 16'h1 << ch});
      check(ladder, i[0]);
      wr(8'h70, ctl | 8'h80);
      #1 t0 = cyc;
      rd(8'h78, {prev, 6'h10});
      rd(8'h70, ctl);
      check(ladder, 1'b1);
      check(sh, 1'b1);
      wait_irq(20000, t1);
      check({sh, dac}, 11'h000);
      check(t1 - t0, lens[i] * 10 + 1);
      res = base + {ch, 3'b101};
      rd(8'h78, {res[1:0], 6'h20});
      if (i[0]) rd(8'h7c, res[9:2]);
      if (i[0]) rd(8'h78, {res[1:0], 6'h00});
      prev = res[1:0];
    end
    // Repeat mode: back-to-back completions, then abort mid-conversion
    wr(8'h74, 8'h10);
    wr(8'h70, {3'b011, 1'b0, ch});
    wr(8'h70, {3'b111, 1'b0, ch});
    wait_irq(2000, t0);
    wait_irq(2000, t1);
    check(t1 - t0, 390);
    base <= ~base;
    // Abort inside the decision phase, so a partial code exists
    repeat (300) @(posedge clk);
    wr(8'h70, {4'h0, ch});
    rd(8'h7c, res[9:2]);
    rd(8'h78, {res[1:0], 6'h00});
    // Reserved mode acts as disable: start is dropped, nothing runs
    wr(8'h70, {4'hc, ch});
    rd(8'h70, {4'h4, ch});
    wait_irq(500, t1);
    check(irq, 1'b0);
    // Standby in mid-conversion
    wr(8'h70, {4'h2, ch});
    wr(8'h70, {4'ha, ch});
    repeat (50) @(posedge clk);
    standby <= 1'b1;
    wr(8'h70, 8'h2f);
    rd(8'h70, 8'h10);
    rd(8'h74, 8'h00);
    standby <= 1'b0;
    rd(8'h78, 8'h00);
    rd(8'h7c, 8'h00);
    check({ladder, in_dis, in_sel}, {2'b01, 16'h0});
    wait_irq(500, t1);
    check(irq, 1'b0);
    // Reserved time code runs the longest conversion
    wr(8'h74, 8'h1e);
    wr(8'h70, {4'h2, ch});
    wr(8'h70, {4'ha, ch});
    #1 t0 = cyc;
    wait_irq(20000, t1);
    check(t1 - t0, 12481);
    tally_and_finish;
  end
endmodule
